// ---- rtl/axis_error_pkg.sv ----
// Package of constants and types shared by both ends of the error poll service.
// Assumes one 20 MHz clock and an active-low asynchronous reset on both ends.
package axis_error_pkg;
  localparam int          NUM_AXES        = 4;
  localparam int          BUF_DEPTH       = 8;
  localparam int          PTR_W           = 4;
  localparam logic [3:0]  FAIL_TOLERANCE  = 4'h5;
  localparam logic [7:0]  SVC_ERROR_POLL  = 8'h01;
  localparam logic [7:0]  SVC_ACTIVATE    = 8'h40;
  localparam logic [7:0]  SVC_POLL_CODE   = 8'h41;
  localparam int          PARAM_FUNC_BYTE = 9;
  localparam int          PARAM_FUNC_BIT  = 6;
  localparam int          REQ_AXIS_LSB    = 0;
  localparam int          REQ_SVC_LSB     = 8;
  localparam int          DIAG_SHORT_LEN  = 16;
  localparam int          DIAG_LONG_LEN   = 62;
  localparam int          DIAG_ALARM_A    = 7;
  localparam int          DIAG_STATUS     = 8;
  localparam int          DIAG_ALARM_B    = 11;
  localparam int          DIAG_RETURN     = 12;
  localparam int          DIAG_AXIS_ECHO  = 19;
  localparam int          STATUS_PROG_BIT = 7;
  localparam int          ALARM_BBR_BIT   = 1;
  localparam int          SHORT_PAIRS     = 1;
  localparam int          LONG_PAIRS      = 4;
  localparam logic [15:0] SVC_REQ_RESET   = 16'h0000;
  // Avalon register offsets of the controller (word addresses).
  localparam logic [3:0]  REG_CMD         = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h1;
  localparam logic [3:0]  REG_RESULT      = 4'h2;
  localparam logic [3:0]  REG_DIAG0       = 4'h4;
  typedef logic [7:0] byte_type;
  typedef logic [15:0] err_type;
endpackage

// ---- rtl/axis_error_if.sv ----
// Interface joining the axis error device and its fieldbus master controller.
// Assumes both ends share one clock; one byte of diagnostics is moved per strobe.
`timescale 1ns/1ps
interface axis_error_if;
  logic        ext_function;
  logic        preset_select;
  logic [15:0] service_request_word;
  logic        service_valid;
  logic        service_ack;
  logic        diag_valid;
  logic        diag_last;
  logic [7:0]  diag_byte;
  logic [5:0]  diag_index;
  logic [31:0] axis_input_data [4];

  modport device (input ext_function, preset_select, service_request_word, service_valid,
                  output service_ack, diag_valid, diag_last, diag_byte, diag_index,
                  axis_input_data);
  modport master (output ext_function, preset_select, service_request_word, service_valid,
                  input service_ack, diag_valid, diag_last, diag_byte, diag_index,
                  axis_input_data);
endinterface

// ---- rtl/axis_error_master.sv ----
// Fieldbus master end: takes orders over Avalon-MM, issues poll requests, gathers replies.
// Assumes software writes the command register and then polls the status register.
`timescale 1ns/1ps
module axis_error_master (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Avalon-MM slave.
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Link.
  axis_error_if.master     link
);
  import axis_error_pkg::*;

  logic        busy_reg;
  logic        start_reg;
  logic        repeat_fail_reg;
  logic        preset_reg;
  logic        enable_reg;
  logic [7:0]  axis_reg;
  logic [15:0] first_err_reg;
  logic [15:0] prev_err_reg;
  logic [7:0]  diag_reg [DIAG_LONG_LEN];
  logic        done_reg;
  logic        answer_end;

  assign waitrequest = 1'b0;
  // Only a frame that ends after the request was acknowledged is the poll answer.
  assign answer_end = link.diag_valid && link.diag_last && busy_reg && !start_reg;
  assign link.ext_function  = enable_reg;
  assign link.preset_select = preset_reg;
  assign link.service_request_word = {SVC_POLL_CODE, axis_reg};
  assign link.service_valid = start_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_reg  <= 1'b0;
      busy_reg   <= 1'b0;
      enable_reg <= 1'b0;
      preset_reg <= 1'b0;
      axis_reg   <= 8'h00;
    end else begin
      if (link.service_ack) begin
        start_reg <= 1'b0;
      end
      if (write && address == REG_CMD && !busy_reg) begin
        axis_reg   <= writedata[7:0];
        preset_reg <= writedata[8];
        enable_reg <= writedata[9];
        start_reg  <= writedata[10];
        busy_reg   <= writedata[10];
      end else if (answer_end) begin
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (link.diag_valid) begin
      diag_reg[link.diag_index] <= link.diag_byte;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      first_err_reg   <= 16'h0000;
      prev_err_reg    <= 16'h0000;
      repeat_fail_reg <= 1'b0;
      done_reg        <= 1'b0;
    end else if (answer_end) begin
      done_reg <= 1'b1;
      if (diag_reg[DIAG_STATUS][STATUS_PROG_BIT]) begin
        first_err_reg   <= {diag_reg[DIAG_RETURN], diag_reg[DIAG_RETURN+1]};
        prev_err_reg    <= first_err_reg;
        repeat_fail_reg <= first_err_reg != 16'h0000 &&
                           first_err_reg == {diag_reg[DIAG_RETURN], diag_reg[DIAG_RETURN+1]};
      end
    end else if (write && address == REG_CMD && !busy_reg) begin
      done_reg <= 1'b0;
    end
  end

  always_comb begin
    readdata = 32'h0000_0000;
    case (address)
      REG_CMD:    readdata = {22'h0, enable_reg, preset_reg, 8'h00} | {24'h0, axis_reg};
      REG_STATUS: readdata = {28'h0, repeat_fail_reg, done_reg, busy_reg,
                              link.axis_input_data[0][31]};
      REG_RESULT: readdata = {prev_err_reg, first_err_reg};
      REG_DIAG0:  readdata = {diag_reg[3], diag_reg[2], diag_reg[1], diag_reg[0]};
      default:    readdata = 32'h0000_0000;
    endcase
  end
endmodule

// ---- rtl/axis_error_device.sv ----
// Device end: per-axis error stacks, error flags, indicators and diagnostics sender.
// Assumes the master holds service_valid until service_ack and reads diagnostics bytes.
//
// Chosen in axis_error_master, not here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module axis_error_device (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Configuration and measurement side.
  input  wire logic        long_diag_mode,
  input  wire logic [3:0]  meas_fail,
  input  wire logic [3:0]  meas_ok,
  input  wire logic [15:0] meas_code [4],
  input  wire logic [29:0] position [4],
  input  wire logic        module_err,
  input  wire logic        module_warn,
  input  wire logic [15:0] module_code,
  input  wire logic        ack_blocked,
  // Indicators.
  output logic      [3:0]  axis_led,
  output logic             module_led,
  // Link.
  axis_error_if.device     link
);
  import axis_error_pkg::*;

  typedef enum logic [1:0] {
    IDLE_STATE = 2'b00,
    POP_STATE  = 2'b01,
    SEND_STATE = 2'b10
  } state_type;

  localparam int N = NUM_AXES + 1;

  state_type   state_reg;
  err_type     stack_reg [N][BUF_DEPTH];
  logic [3:0]  depth_reg [N];
  logic [3:0]  fail_cnt_reg [NUM_AXES];
  logic [N-1:0] push;
  err_type     push_code [N];
  logic [N-1:0] pop;
  logic        warn_reg;
  logic        alarm_pend_reg;
  logic        poll_reg;
  logic [7:0]  axis_sel_reg;
  err_type     pair_reg [LONG_PAIRS];
  logic [2:0]  pair_cnt_reg;
  logic [5:0]  idx_reg;
  logic [2:0]  sel;
  logic [3:0]  dsel;
  logic        any_err;
  logic [7:0]  byte_next;
  logic [5:0]  last_idx;
  logic        poll_req;

  assign sel  = (axis_sel_reg == 8'h00) ? 3'(NUM_AXES) : 3'(axis_sel_reg - 8'h01);
  assign dsel = depth_reg[sel];
  assign any_err = |{depth_reg[0], depth_reg[1], depth_reg[2], depth_reg[3], depth_reg[4]};
  assign last_idx = long_diag_mode ? 6'(DIAG_LONG_LEN - 1) : 6'(DIAG_SHORT_LEN - 1);
  assign poll_req = link.service_valid && link.ext_function &&
                    link.service_request_word[REQ_SVC_LSB +: 8] == SVC_POLL_CODE;

  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : gen_axis
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          fail_cnt_reg[g] <= 4'h0;
        end else if (meas_ok[g]) begin
          fail_cnt_reg[g] <= 4'h0;
        end else if (meas_fail[g] && fail_cnt_reg[g] != 4'hf) begin
          fail_cnt_reg[g] <= fail_cnt_reg[g] + 4'h1;
        end
      end
      assign push[g] = meas_fail[g] && fail_cnt_reg[g] == FAIL_TOLERANCE;
      assign push_code[g] = meas_code[g];
      assign axis_led[g] = depth_reg[g] != 4'h0;
      assign link.axis_input_data[g] = {depth_reg[g] != 4'h0, 1'b0, position[g]};
    end
  endgenerate
  assign push[NUM_AXES]      = module_err || module_warn;
  assign push_code[NUM_AXES] = module_code;
  assign module_led = depth_reg[NUM_AXES] != 4'h0 || warn_reg;

  generate
    for (g = 0; g < N; g++) begin : gen_stack
      assign pop[g] = state_reg == POP_STATE && sel == 3'(g) && depth_reg[g] != 4'h0 &&
                      pair_cnt_reg < (long_diag_mode ? 3'(LONG_PAIRS) : 3'(SHORT_PAIRS)) &&
                      !ack_blocked;
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          depth_reg[g] <= 4'h0;
        end else if (push[g] && !pop[g] && depth_reg[g] != 4'(BUF_DEPTH)) begin
          depth_reg[g] <= depth_reg[g] + 4'h1;
        end else if (pop[g] && !push[g]) begin
          depth_reg[g] <= depth_reg[g] - 4'h1;
        end
      end
      always_ff @(posedge clock) begin
        if (push[g] && (depth_reg[g] != 4'(BUF_DEPTH) || pop[g])) begin
          stack_reg[g][3'(depth_reg[g] - 4'(pop[g]))] <= push_code[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      warn_reg <= 1'b0;
    end else if (module_warn) begin
      warn_reg <= 1'b1;
    end else if (pop[NUM_AXES] && depth_reg[NUM_AXES] == 4'h1) begin
      warn_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= IDLE_STATE;
      alarm_pend_reg <= 1'b0;
      poll_reg       <= 1'b0;
      axis_sel_reg   <= 8'h00;
      pair_cnt_reg   <= 3'h0;
      idx_reg        <= 6'h00;
      for (int i = 0; i < LONG_PAIRS; i++) begin
        pair_reg[i] <= 16'h0000;
      end
    end else begin
      if (|push) begin
        alarm_pend_reg <= 1'b1;
      end
      case (state_reg)
        IDLE_STATE: begin
          if (poll_req) begin
            axis_sel_reg <= link.service_request_word[REQ_AXIS_LSB +: 8];
            poll_reg     <= 1'b1;
            pair_cnt_reg <= 3'h0;
            for (int i = 0; i < LONG_PAIRS; i++) begin
              pair_reg[i] <= 16'h0000;
            end
            state_reg <= POP_STATE;
          end else if (alarm_pend_reg && !(|push)) begin
            alarm_pend_reg <= 1'b0;
            poll_reg       <= 1'b0;
            idx_reg        <= 6'h00;
            state_reg      <= SEND_STATE;
          end
        end
        POP_STATE: begin
          if (dsel != 4'h0 &&
              pair_cnt_reg < (long_diag_mode ? 3'(LONG_PAIRS) : 3'(SHORT_PAIRS))) begin
            pair_reg[pair_cnt_reg[1:0]] <= stack_reg[sel][3'(dsel - 4'h1)];
            pair_cnt_reg <= pair_cnt_reg + 3'h1;
            if (ack_blocked) begin
              pair_cnt_reg <= 3'h4;
            end
          end else begin
            idx_reg   <= 6'h00;
            state_reg <= SEND_STATE;
          end
        end
        SEND_STATE: begin
          idx_reg <= idx_reg + 6'h01;
          if (idx_reg == last_idx) begin
            state_reg <= IDLE_STATE;
          end
        end
        default: state_reg <= IDLE_STATE;
      endcase
    end
  end

  // Only a valid poll is acknowledged, so a stray request never looks answered.
  assign link.service_ack = state_reg == IDLE_STATE && poll_req;

  always_comb begin
    byte_next = 8'h00;
    case (idx_reg)
      6'(DIAG_ALARM_A): byte_next = {7'h00, any_err};
      6'(DIAG_ALARM_B): byte_next = {6'h00, any_err, any_err};
      6'(DIAG_STATUS):  byte_next = {poll_reg, 7'h00};
      6'(DIAG_AXIS_ECHO): byte_next = poll_reg ? axis_sel_reg : 8'h00;
      default: begin
        if (poll_reg && idx_reg >= 6'(DIAG_RETURN) && idx_reg < 6'(DIAG_RETURN + 8)) begin
          byte_next = idx_reg[0] ? pair_reg[2'((idx_reg - 6'(DIAG_RETURN)) >> 1)][7:0]
                                 : pair_reg[2'((idx_reg - 6'(DIAG_RETURN)) >> 1)][15:8];
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      link.diag_valid <= 1'b0;
      link.diag_last  <= 1'b0;
      link.diag_byte  <= 8'h00;
      link.diag_index <= 6'h00;
    end else begin
      link.diag_valid <= state_reg == SEND_STATE;
      link.diag_last  <= state_reg == SEND_STATE && idx_reg == last_idx;
      link.diag_byte  <= byte_next;
      link.diag_index <= idx_reg;
    end
  end
endmodule

// ---- sim/axis_error_assertions.sv ----
// Checker of the link between the poll service master and the axis error device.
// Assumes one clock and an active-low reset shared by both ends.
`timescale 1ns/1ps
module axis_error_assertions (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        reset_n,
  // Request side.
  input wire logic        ext_function,
  input wire logic [15:0] service_request_word,
  input wire logic        service_valid,
  input wire logic        service_ack,
  // Diagnostics side.
  input wire logic        diag_valid,
  input wire logic        diag_last,
  input wire logic [7:0]  diag_byte,
  input wire logic [5:0]  diag_index
);
  import axis_error_pkg::*;
  logic [7:0] axis_reg;
  logic       poll_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      axis_reg <= 8'h00;
    end else if (service_ack) begin
      axis_reg <= service_request_word[7:0];
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      poll_reg <= 1'b0;
    end else if (diag_valid && diag_index == 6'd8) begin
      poll_reg <= diag_byte[7];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_next_byte;
    diag_valid && diag_index == $past(diag_index) + 6'd1;
  endsequence
  sequence s_poll_status;
    service_ack ##[1:20] (diag_valid && diag_index == 6'd8);
  endsequence
  a_ack_request: assert property (service_ack |-> service_valid && ext_function
    && service_request_word[15:8] == SVC_POLL_CODE) else $error("bad request taken");
  a_frame_step: assert property (diag_valid && !diag_last |=> s_next_byte)
    else $error("diag frame broken");
  a_frame_end: assert property (diag_last |-> diag_valid
    && (diag_index == 6'd15 || diag_index == 6'd61)) else $error("diag length wrong");
  a_frame_start: assert property ($rose(diag_valid) |-> diag_index == 6'd0)
    else $error("diag frame not at byte 0");
  a_answer_soon: assert property (service_ack |-> ##[1:20] diag_valid)
    else $error("poll answer missing");
  a_poll_marked: assert property (s_poll_status |-> diag_byte[7])
    else $error("poll answer not marked");
  a_axis_echo: assert property (diag_valid && diag_index == 6'd19 && poll_reg
    |-> diag_byte == axis_reg) else $error("axis echo wrong");
  a_alarm_clean: assert property (diag_valid && !poll_reg && diag_index >= 6'd12
    && diag_index <= 6'd18 |-> diag_byte == 8'h00) else $error("alarm has numbers");
endmodule

// ---- sim/tb_top.sv ----
// Testbench joining master and device ends through the link interface.
// Assumes axis k of a request uses per-axis port index k-1; axis 0 is the module.
`timescale 1ns/1ps
module tb_top;
  import axis_error_pkg::*;
  logic        clock, reset_n, read, write, waitrequest;
  logic [3:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic        long_diag_mode, module_err, module_warn, ack_blocked, module_led;
  logic [3:0]  meas_fail, meas_ok, axis_led;
  logic [15:0] meas_code [4];
  logic [29:0] position [4];
  logic [15:0] module_code;
  logic [7:0]  diag_seen [64];
  int          diag_len, error_cnt, num_checks;
  logic [23:0] push_rows [4] = '{24'h01_A001, 24'h01_A002, 24'h02_B001, 24'h00_C001};
  logic [23:0] poll_rows [7] = '{24'h01_A002, 24'h01_A001, 24'h01_0000, 24'h02_B001,
                                 24'h02_0000, 24'h00_C001, 24'h00_0000};
  axis_error_if link_if ();
  axis_error_master axis_error_master_inst (.clock, .reset_n, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .link(link_if));
  axis_error_device axis_error_device_inst (.clock, .reset_n, .long_diag_mode, .meas_fail,
    .meas_ok, .meas_code, .position, .module_err, .module_warn, .module_code, .ack_blocked,
    .axis_led, .module_led, .link(link_if));
  axis_error_assertions axis_error_assertions_inst (.clock, .reset_n,
    .ext_function(link_if.ext_function), .service_request_word(link_if.service_request_word),
    .service_valid(link_if.service_valid), .service_ack(link_if.service_ack),
    .diag_valid(link_if.diag_valid), .diag_last(link_if.diag_last),
    .diag_byte(link_if.diag_byte), .diag_index(link_if.diag_index));
  always @(posedge clock) begin
    if (link_if.diag_valid === 1'b1) begin
      diag_seen[link_if.diag_index] <= link_if.diag_byte;
      if (link_if.diag_last === 1'b1) begin
        diag_len <= int'(link_if.diag_index) + 1;
      end
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
    if (n >= 100) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic poll(input logic [8:0] req);
    int n;
    n = 0;
    av_xfer(1'b1, REG_CMD, 32'h0000_0600 | {23'h00_0000, req});
    av_xfer(1'b0, REG_STATUS, 32'h0000_0000);
    while ((rd[1] !== 1'b0 || rd[2] !== 1'b1) && n < 200) begin
      av_xfer(1'b0, REG_STATUS, 32'h0000_0000);
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      end_sim();
    end
    av_xfer(1'b0, REG_RESULT, 32'h0000_0000);
  endtask
  task automatic pulse_ok(input int ax);
    meas_ok[ax-1] <= 1'b1;
    @(posedge clock);
    meas_ok[ax-1] <= 1'b0;
    @(posedge clock);
  endtask
  task automatic inject(input int ax, input logic [15:0] code, input int n, input logic ok);
    if (ax == 0) begin
      module_code <= code;
      module_err <= 1'b1;
      @(posedge clock);
      module_err <= 1'b0;
    end else begin
      meas_code[ax-1] <= code;
      repeat (n) begin
        meas_fail[ax-1] <= 1'b1;
        @(posedge clock);
        meas_fail[ax-1] <= 1'b0;
        @(posedge clock);
      end
      if (ok) begin
        pulse_ok(ax);
      end
    end
    @(posedge clock);
  endtask
  task automatic wait_frame();
    int n;
    n = 0;
    while (link_if.diag_last !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    @(posedge clock);
    if (n >= 100) begin
      error_cnt++;
      end_sim();
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    reset_n = 1'b0;
    {address, read, write, writedata} = '0;
    {long_diag_mode, meas_fail, meas_ok, module_err, module_warn, ack_blocked} = '0;
    module_code = 16'h0000;
    diag_len = 0;
    error_cnt = 0;
    num_checks = 0;
    for (int i = 0; i < 4; i++) begin
      meas_code[i] = 16'h0000;
      position[i] = 30'h0000_1000 + 30'(i);
    end
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    check("leds", {27'h000_0000, module_led, axis_led}, 32'h0000_0000);
    av_xfer(1'b0, REG_STATUS, 32'h0000_0000);
    check("status", rd, 32'h0000_0000);
    av_xfer(1'b0, 4'h7, 32'h0000_0000);
    check("unmapped", rd, 32'h0000_0000);
    $display("reset test done");
    foreach (push_rows[i]) inject(int'(push_rows[i][23:16]), push_rows[i][15:0], 6, 1'b1);
    check("flag1", link_if.axis_input_data[0][31], 1'b1);
    check("axis_led", axis_led, 4'b0011);
    check("module_led", module_led, 1'b1);
    foreach (poll_rows[i]) begin
      poll({1'b0, poll_rows[i][23:16]});
      check("result", rd[15:0], poll_rows[i][15:0]);
      check("diag_len", diag_len, 16);
      check("prog_bit", diag_seen[8][7], 1'b1);
    end
    check("leds", {module_led, axis_led}, 5'h00);
    check("alarm_clr", {diag_seen[7], diag_seen[11]}, 16'h0000);
    check("flag1", link_if.axis_input_data[0][31], 1'b0);
    $display("table test done");
    inject(3, 16'hD001, 5, 1'b0);
    check("flag3", link_if.axis_input_data[2][31], 1'b0);
    inject(3, 16'hD001, 1, 1'b0);
    wait_frame();
    pulse_ok(3);
    check("flag3", link_if.axis_input_data[2][31], 1'b1);
    check("alarm_prog", diag_seen[8][7], 1'b0);
    check("report", diag_seen[11][1], 1'b1);
    check("alarm_num", diag_seen[12], 8'h00);
    ack_blocked <= 1'b1;
    poll(9'h103);
    poll(9'h103);
    check("repeat", rd, 32'hD001_D001);
    check("preset", link_if.preset_select, 1'b1);
    av_xfer(1'b0, REG_STATUS, 32'h0000_0000);
    check("rep_bit", rd[3], 1'b1);
    ack_blocked <= 1'b0;
    poll(9'h003);
    check("result", rd[15:0], 16'hD001);
    check("flag3", {axis_led[2], link_if.axis_input_data[2][31]}, 2'b00);
    $display("tolerance and repeat test done");
    module_warn <= 1'b1;
    @(posedge clock);
    module_warn <= 1'b0;
    repeat (2) @(posedge clock);
    check("warn_led", module_led, 1'b1);
    check("warn_flag", link_if.axis_input_data[0][31], 1'b0);
    poll(9'h000);
    check("warn_code", rd[15:0], 16'hC001);
    check("warn_led", module_led, 1'b0);
    for (int i = 1; i <= 9; i++) inject(1, 16'hE000 + 16'(i), 6, 1'b1);
    for (int i = 8; i >= 0; i--) begin
      poll(9'h001);
      check("stack", rd[15:0], (i == 0) ? 16'h0000 : 16'hE000 + 16'(i));
    end
    $display("warning and depth test done");
    long_diag_mode <= 1'b1;
    inject(2, 16'hF001, 6, 1'b1);
    inject(2, 16'hF002, 6, 1'b1);
    poll(9'h002);
    check("long_len", diag_len, 62);
    check("echo", diag_seen[19], 8'h02);
    check("pair", {diag_seen[12], diag_seen[13]}, 16'hF002);
    check("led2", axis_led[1], 1'b0);
    $display("long mode test done");
    end_sim();
  end
endmodule
